/* pfp_defs.svh */
// Constants of the pin-fault protection sequencer.
// Assumes a 40 MHz pclk; included by the run counter, the sequencer and the testbench.
`ifndef PFP_DEFS_SVH
`define PFP_DEFS_SVH
`define PFP_CLK_NS          25
`define PFP_BIAS_SAMPLE_NS  10000
`define PFP_PROG_SETTLE_NS  5000
`define PFP_LIMIT_LONG_NS   2000
`define PFP_LIMIT_SHORT_NS  1000
`define PFP_RECOVERY_MS     1500
`define PFP_NS_PER_MS       1000000
`define PFP_RUN_LENGTH      3
`define PFP_A_CTRL          8'h00
`define PFP_A_PERIOD        8'h04
`define PFP_A_MAXON         8'h08
`define PFP_A_STATE         8'h0C
`define PFP_A_IRQ_STATUS    8'h10
`define PFP_A_IRQ_ENABLE    8'h14
`define PFP_A_IRQ_CLEAR     8'h18
`define PFP_CTRL_ENABLE     0
`define PFP_CTRL_RST        1'b1
`define PFP_PERIOD_RST      16'h0064
`define PFP_MAXON_RST       16'h0028
`define PFP_EV_W            6
`define PFP_EV_CS_SHORT     0
`define PFP_EV_CS_OPEN      1
`define PFP_EV_BIAS_OPEN    2
`define PFP_EV_BIAS_OV      3
`define PFP_EV_PROG_OPEN    4
`define PFP_EV_PROG_SHORT   5
`endif

/* pfp_pkg.sv */
// Types of the pin-fault protection sequencer.
// Assumes nothing of its surroundings.
package pfp_pkg;
    typedef enum logic [2:0] {
        ST_OFF     = 3'h0,
        ST_PROG    = 3'h1,
        ST_BIAS    = 3'h3,
        ST_RUN     = 3'h2,
        ST_RECOVER = 3'h6,
        ST_UVLO    = 3'h4
    } state_e;
endpackage

/* pulse_run_counter.sv */
// Counter of consecutive gate pulses that saw a fault comparator.
// Assumes done is a one-cycle pulse at each gate pulse end.
`timescale 1ns/1ps
`include "pfp_defs.svh"
module pulse_run_counter #(
    parameter int RUN = `PFP_RUN_LENGTH
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clear,
    input  wire logic done,
    input  wire logic seen,
    output logic      trip
);
    logic [3:0] cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 4'h0;
        end else if (clear) begin
            cnt_reg <= 4'h0;
        end else if (done) begin
            cnt_reg <= seen ? cnt_reg + 4'h1 : 4'h0;
        end
    end

    assign trip = (cnt_reg == 4'(RUN));

    property p_run_clear;
        @(posedge pclk) disable iff (!presetn)
        done && !seen && !clear |=> cnt_reg == 4'h0;
    endproperty
    a_run_clear: assert property (p_run_clear)
        else $error("run counter not cleared by clean pulse");
endmodule // pulse_run_counter

/* pin_fault_protection.sv */
// Pin-fault protection sequencer with APB register access.
// Assumes analog comparators on pins, asynchronous to pclk (40 MHz).
`timescale 1ns/1ps
`include "pfp_defs.svh"
module pin_fault_protection #(
    parameter int unsigned RECOVERY_CYCLES =
        `PFP_RECOVERY_MS * `PFP_NS_PER_MS / `PFP_CLK_NS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        supply_on,
    input  wire logic        stage_select_high,
    input  wire logic        cs_peak,
    input  wire logic        cs_over,
    input  wire logic        bias_below14,
    input  wire logic        bias_over15,
    input  wire logic        demag_above_threshold,
    input  wire logic        demag_open,
    input  wire logic        demag_short,
    input  wire logic        zvs_open,
    input  wire logic        zvs_short,
    output logic             low_side_gate_pulse,
    output logic             prog_bias_en,
    output logic             bias_regulate_en,
    output logic             uvlo_request,
    output logic             irq
);
    localparam int BIAS_CYC =
        (`PFP_BIAS_SAMPLE_NS + `PFP_CLK_NS - 1) / `PFP_CLK_NS;
    localparam int PROG_CYC =
        (`PFP_PROG_SETTLE_NS + `PFP_CLK_NS - 1) / `PFP_CLK_NS;
    localparam int LONG_CYC  = `PFP_LIMIT_LONG_NS / `PFP_CLK_NS;
    localparam int SHORT_CYC = `PFP_LIMIT_SHORT_NS / `PFP_CLK_NS;

    // Two-flop synchronisers for all pin inputs
    logic [10:0] sync1_reg;
    logic [10:0] sync2_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 11'h000;
            sync2_reg <= 11'h000;
        end else begin
            sync1_reg <= {supply_on, stage_select_high, cs_peak, cs_over,
                          bias_below14, bias_over15, demag_above_threshold,
                          demag_open, demag_short, zvs_open, zvs_short};
            sync2_reg <= sync1_reg;
        end
    end

    logic supply_s, set_s, peak_s, csov_s, below_s, over_s, dhi_s;
    logic prog_open_s, prog_short_s;
    assign supply_s     = sync2_reg[10];
    assign set_s        = sync2_reg[9];
    assign peak_s       = sync2_reg[8];
    assign csov_s       = sync2_reg[7];
    assign below_s      = sync2_reg[6];
    assign over_s       = sync2_reg[5];
    assign dhi_s        = sync2_reg[4];
    assign prog_open_s  = sync2_reg[3] | sync2_reg[1];
    assign prog_short_s = sync2_reg[2] | sync2_reg[0];

    // Registers
    logic                 enable_reg;
    logic [15:0]          period_reg;
    logic [15:0]          maxon_reg;
    logic [`PFP_EV_W-1:0] ev_status_reg;
    logic [`PFP_EV_W-1:0] ev_enable_reg;

    pfp_pkg::state_e state_reg;
    logic [31:0]     tmr_reg;
    logic [15:0]     per_cnt_reg;
    logic [15:0]     on_cnt_reg;
    logic            gate_reg;
    logic            first_reg;
    logic            dhi_reg;
    logic            cs_seen_reg;
    logic            ov_seen_reg;

    // APB handshake: one wait state, answer registered
    logic apb_done;
    logic apb_wr;
    assign apb_done = psel & penable & pready;
    assign apb_wr   = apb_done & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel & penable & ~pready) begin
                unique case (paddr)
                    `PFP_A_CTRL:       prdata <= {31'h0, enable_reg};
                    `PFP_A_PERIOD:     prdata <= {16'h0, period_reg};
                    `PFP_A_MAXON:      prdata <= {16'h0, maxon_reg};
                    `PFP_A_STATE:      prdata <= {29'h0, state_reg};
                    `PFP_A_IRQ_STATUS: prdata <= {26'h0, ev_status_reg};
                    `PFP_A_IRQ_ENABLE: prdata <= {26'h0, ev_enable_reg};
                    `PFP_A_IRQ_CLEAR:  prdata <= 32'h0000_0000;
                    default:           pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg    <= `PFP_CTRL_RST;
            period_reg    <= `PFP_PERIOD_RST;
            maxon_reg     <= `PFP_MAXON_RST;
            ev_enable_reg <= '0;
        end else if (apb_wr) begin
            if (paddr == `PFP_A_CTRL) begin
                enable_reg <= pwdata[`PFP_CTRL_ENABLE];
            end
            if (paddr == `PFP_A_PERIOD) begin
                period_reg <= pwdata[15:0];
            end
            if (paddr == `PFP_A_MAXON) begin
                maxon_reg <= pwdata[15:0];
            end
            if (paddr == `PFP_A_IRQ_ENABLE) begin
                ev_enable_reg <= pwdata[`PFP_EV_W-1:0];
            end
        end
    end

    // Pulse timing
    logic [15:0] limit;
    logic        on_hit;
    logic        pulse_end;
    logic        short_evt;
    logic        cs_trip;
    logic        ov_trip;
    logic        run_clear;

    always_comb begin
        if (!first_reg) begin
            limit = maxon_reg;
        end else if (set_s || dhi_reg) begin
            limit = 16'(LONG_CYC);
        end else begin
            limit = 16'(SHORT_CYC);
        end
    end

    assign on_hit    = (on_cnt_reg + 16'h1 >= limit);
    assign pulse_end = gate_reg & (peak_s | on_hit);
    assign short_evt = pulse_end & first_reg & ~peak_s;
    assign run_clear = (state_reg != pfp_pkg::ST_RUN);

    pulse_run_counter #(.RUN(`PFP_RUN_LENGTH)) u_cs_run (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (run_clear),
        .done    (pulse_end),
        .seen    (cs_seen_reg | csov_s),
        .trip    (cs_trip)
    );

    pulse_run_counter #(.RUN(`PFP_RUN_LENGTH)) u_ov_run (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (run_clear),
        .done    (pulse_end),
        .seen    (ov_seen_reg | over_s),
        .trip    (ov_trip)
    );

    logic prog_check;
    logic bias_check;
    assign prog_check = (state_reg == pfp_pkg::ST_PROG) &&
                        (tmr_reg == 32'(PROG_CYC - 1));
    // Bias sample counted from supply turn-on
    assign bias_check = (state_reg == pfp_pkg::ST_BIAS) &&
                        (tmr_reg == 32'(BIAS_CYC - PROG_CYC - 1));

    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= pfp_pkg::ST_OFF;
            tmr_reg   <= 32'h0000_0000;
            dhi_reg   <= 1'b0;
        end else begin
            tmr_reg <= tmr_reg + 32'h1;
            unique case (state_reg)
                pfp_pkg::ST_OFF: begin
                    tmr_reg <= 32'h0000_0000;
                    if (supply_s) begin
                        state_reg <= pfp_pkg::ST_PROG;
                    end
                end
                pfp_pkg::ST_PROG: begin
                    if (prog_check) begin
                        tmr_reg <= 32'h0000_0000;
                        dhi_reg <= dhi_s;
                        if (prog_open_s || prog_short_s) begin
                            state_reg <= pfp_pkg::ST_UVLO;
                        end else begin
                            state_reg <= pfp_pkg::ST_BIAS;
                        end
                    end
                end
                // Sample bias pin at 10 us
                pfp_pkg::ST_BIAS: begin
                    if (bias_check) begin
                        tmr_reg   <= 32'h0000_0000;
                        state_reg <= below_s ? pfp_pkg::ST_UVLO
                                             : pfp_pkg::ST_RUN;
                    end
                end
                pfp_pkg::ST_RUN: begin
                    tmr_reg <= 32'h0000_0000;
                    if (short_evt || cs_trip) begin
                        state_reg <= pfp_pkg::ST_RECOVER;
                    end else if (ov_trip) begin
                        state_reg <= pfp_pkg::ST_UVLO;
                    end
                end
                pfp_pkg::ST_RECOVER: begin
                    if (tmr_reg >= RECOVERY_CYCLES - 1) begin
                        state_reg <= pfp_pkg::ST_UVLO;
                    end
                end
                pfp_pkg::ST_UVLO: begin
                    tmr_reg <= 32'h0000_0000;
                    if (!supply_s) begin
                        state_reg <= pfp_pkg::ST_OFF;
                    end
                end
                default: begin
                    state_reg <= pfp_pkg::ST_UVLO;
                end
            endcase
            if (!supply_s && state_reg != pfp_pkg::ST_UVLO) begin
                state_reg <= pfp_pkg::ST_OFF;
            end
        end
    end

    // Gate pulse generation
    logic go_run;
    assign go_run = (state_reg == pfp_pkg::ST_RUN) && supply_s &&
                    !short_evt && !cs_trip && !ov_trip;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_reg    <= 1'b0;
            first_reg   <= 1'b1;
            per_cnt_reg <= 16'h0000;
            on_cnt_reg  <= 16'h0000;
            cs_seen_reg <= 1'b0;
            ov_seen_reg <= 1'b0;
        end else if (!go_run) begin
            gate_reg    <= 1'b0;
            per_cnt_reg <= 16'h0000;
            on_cnt_reg  <= 16'h0000;
            cs_seen_reg <= 1'b0;
            ov_seen_reg <= 1'b0;
            if (state_reg != pfp_pkg::ST_RUN) begin
                first_reg <= 1'b1;
            end
        end else begin
            per_cnt_reg <= (per_cnt_reg + 16'h1 >= period_reg) ?
                           16'h0000 : per_cnt_reg + 16'h1;
            if (gate_reg) begin
                on_cnt_reg  <= on_cnt_reg + 16'h1;
                cs_seen_reg <= cs_seen_reg | csov_s;
                ov_seen_reg <= ov_seen_reg | over_s;
                if (pulse_end) begin
                    gate_reg  <= 1'b0;
                    first_reg <= 1'b0;
                end
            end else if (per_cnt_reg == 16'h0000 && enable_reg) begin
                gate_reg    <= 1'b1;
                on_cnt_reg  <= 16'h0000;
                cs_seen_reg <= 1'b0;
                ov_seen_reg <= 1'b0;
            end
        end
    end

    // Events, sticky status; set wins over clear
    logic [`PFP_EV_W-1:0] ev_set;
    logic [`PFP_EV_W-1:0] ev_clr;
    always_comb begin
        ev_set = '0;
        ev_set[`PFP_EV_CS_SHORT]   = short_evt &&
                                     state_reg == pfp_pkg::ST_RUN;
        ev_set[`PFP_EV_CS_OPEN]    = cs_trip && !short_evt;
        ev_set[`PFP_EV_BIAS_OPEN]  = bias_check && below_s;
        ev_set[`PFP_EV_BIAS_OV]    = ov_trip && !short_evt && !cs_trip;
        ev_set[`PFP_EV_PROG_OPEN]  = prog_check && prog_open_s;
        ev_set[`PFP_EV_PROG_SHORT] = prog_check && prog_short_s;
        ev_clr = (apb_wr && paddr == `PFP_A_IRQ_CLEAR) ?
                 pwdata[`PFP_EV_W-1:0] : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_status_reg <= '0;
        end else begin
            ev_status_reg <= (ev_status_reg & ~ev_clr) | ev_set;
        end
    end

    // Outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq              <= 1'b0;
            prog_bias_en     <= 1'b0;
            bias_regulate_en <= 1'b0;
            uvlo_request     <= 1'b0;
        end else begin
            irq          <= |(ev_status_reg & ev_enable_reg);
            prog_bias_en <= (state_reg == pfp_pkg::ST_OFF && supply_s) ||
                            (state_reg == pfp_pkg::ST_PROG && !prog_check);
            bias_regulate_en <= (state_reg == pfp_pkg::ST_PROG ||
                                 state_reg == pfp_pkg::ST_BIAS ||
                                 state_reg == pfp_pkg::ST_RUN) && supply_s;
            uvlo_request <= (state_reg == pfp_pkg::ST_UVLO) && supply_s;
        end
    end
    assign low_side_gate_pulse = gate_reg;

    property p_first_only;
        @(posedge pclk) disable iff (!presetn)
        pulse_end && !first_reg |=> state_reg != pfp_pkg::ST_RECOVER
            || $past(cs_trip);
    endproperty
    a_first_only: assert property (p_first_only)
        else $error("short trip on a later pulse");

    property p_long_limit;
        @(posedge pclk) disable iff (!presetn)
        gate_reg && first_reg && set_s |-> on_cnt_reg < 16'(LONG_CYC);
    endproperty
    a_long_limit: assert property (p_long_limit)
        else $error("first pulse exceeds long limit");

    property p_short_recover;
        @(posedge pclk) disable iff (!presetn)
        short_evt && supply_s |=> state_reg == pfp_pkg::ST_RECOVER
            && !gate_reg;
    endproperty
    a_short_recover: assert property (p_short_recover)
        else $error("sense short did not start recovery");

    property p_short_limit;
        @(posedge pclk) disable iff (!presetn)
        gate_reg && first_reg && !set_s && !dhi_reg
            |-> on_cnt_reg < 16'(SHORT_CYC);
    endproperty
    a_short_limit: assert property (p_short_limit)
        else $error("first pulse exceeds short limit");

    property p_open_recover;
        @(posedge pclk) disable iff (!presetn)
        cs_trip && state_reg == pfp_pkg::ST_RUN && supply_s
            |=> state_reg == pfp_pkg::ST_RECOVER ##1 !gate_reg;
    endproperty
    a_open_recover: assert property (p_open_recover)
        else $error("sense open did not stop switching");

    property p_bias_first;
        @(posedge pclk) disable iff (!presetn)
        $rose(gate_reg) |-> bias_regulate_en && $past(bias_regulate_en);
    endproperty
    a_bias_first: assert property (p_bias_first)
        else $error("gate pulse without bias regulation");

    property p_bias_low;
        @(posedge pclk) disable iff (!presetn)
        bias_check && below_s && supply_s
            |=> state_reg == pfp_pkg::ST_UVLO ##1 uvlo_request || !supply_s;
    endproperty
    a_bias_low: assert property (p_bias_low)
        else $error("bias low did not force UVLO");

    property p_bias_ov;
        @(posedge pclk) disable iff (!presetn)
        ov_trip && go_run == 1'b0 && state_reg == pfp_pkg::ST_RUN
            && !short_evt && !cs_trip && supply_s
            |=> state_reg == pfp_pkg::ST_UVLO;
    endproperty
    a_bias_ov: assert property (p_bias_ov)
        else $error("bias over-voltage run did not force UVLO");

    property p_prog_bias;
        @(posedge pclk) disable iff (!presetn)
        prog_bias_en |-> $past(state_reg) != pfp_pkg::ST_RUN && !gate_reg;
    endproperty
    a_prog_bias: assert property (p_prog_bias)
        else $error("program pins biased while switching");

    property p_prog_fault;
        @(posedge pclk) disable iff (!presetn)
        prog_check && (prog_open_s || prog_short_s) && supply_s
            |=> state_reg == pfp_pkg::ST_UVLO && !gate_reg;
    endproperty
    a_prog_fault: assert property (p_prog_fault)
        else $error("program fault did not inhibit switching");
endmodule // pin_fault_protection

/* power_stage_model.sv */
// Model of the flyback power stage and its sense network.
// Assumes gate level from the sequencer and supply level from the testbench, one clock.
`timescale 1ns/1ps
module power_stage_model (
    input  wire logic       pclk,
    input  wire logic       gate,
    input  wire logic       supply_on,
    input  wire logic [7:0] peak_cycles,
    input  wire logic [7:0] cs_mask,
    input  wire logic [7:0] ov_mask,
    input  wire logic       bias_open,
    output logic            cs_peak,
    output logic            cs_over,
    output logic            bias_over15,
    output logic            bias_below14
);
    logic [7:0] hi_cnt = 8'h00;
    logic [3:0] idx    = 4'h0;
    logic       gate_d = 1'b0;
    // Pulse index since supply up and high time of this pulse
    always @(posedge pclk) begin
        gate_d <= gate;
        hi_cnt <= gate ? hi_cnt + 8'h01 : 8'h00;
        if (!supply_on)
            idx <= 4'h0;
        else if (gate_d && !gate && idx != 4'hF)
            idx <= idx + 4'h1;
    end
    // Zero peak_cycles models a shorted sense pin
    assign cs_peak = gate && peak_cycles != 8'h00 && hi_cnt >= peak_cycles;
    assign cs_over = gate && !idx[3] && cs_mask[idx[2:0]];
    assign bias_over15 = gate && !idx[3] && ov_mask[idx[2:0]];
    assign bias_below14 = bias_open;
endmodule // power_stage_model

/* pin_fault_protection_tb.sv */
// Testbench of the pin-fault protection sequencer.
// Assumes the power stage model and APB access at 40 MHz.
`timescale 1ns/1ps
`include "pfp_defs.svh"
module pin_fault_protection_tb;
    localparam int unsigned RC = 50;
    localparam int LONG = `PFP_LIMIT_LONG_NS / `PFP_CLK_NS;
    localparam int SHORT = `PFP_LIMIT_SHORT_NS / `PFP_CLK_NS;
    localparam int BIAS10 = `PFP_BIAS_SAMPLE_NS / `PFP_CLK_NS;
    localparam logic [2:0] UV = pfp_pkg::ST_UVLO;
    localparam logic [2:0] RN = pfp_pkg::ST_RUN;
    typedef struct packed {
        logic       sel;
        logic       dem;
        logic [7:0] peak;
        logic [7:0] csm;
        logic [7:0] ovm;
        logic       bopen;
        logic [3:0] prog;
        logic [5:0] stat;
    } row_s;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        supply_on = 1'b0;
    logic        sel = 1'b0;
    logic        dem = 1'b0;
    logic        bopen = 1'b0;
    logic [3:0]  prog = 4'h0;
    logic [7:0]  peak = 8'h00;
    logic [7:0]  csm = 8'h00;
    logic [7:0]  ovm = 8'h00;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, err, gate, gate_d, uvlo, uvlo_d, irq;
    logic        cs_peak, cs_over, bias_over15, bias_below14, pbias, breg;
    int          failures = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          fall_c = 0;
    int          rise_c = 0;
    int          grise_c = 0;
    row_s        rows [12];
    logic [39:0] regs [7];

    pin_fault_protection #(.RECOVERY_CYCLES(RC)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .supply_on, .cs_peak, .cs_over, .irq,
        .stage_select_high(sel), .bias_below14, .bias_over15,
        .demag_above_threshold(dem), .demag_open(prog[0]),
        .demag_short(prog[1]), .zvs_open(prog[2]), .zvs_short(prog[3]),
        .low_side_gate_pulse(gate), .prog_bias_en(pbias),
        .bias_regulate_en(breg), .uvlo_request(uvlo));
    power_stage_model psm (
        .pclk, .gate, .supply_on, .peak_cycles(peak), .cs_mask(csm),
        .ov_mask(ovm), .bias_open(bopen), .cs_peak, .cs_over,
        .bias_over15, .bias_below14);

    always #12.5 pclk = ~pclk;
    // Edge times of gate and undervoltage request
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        gate_d <= gate;
        uvlo_d <= uvlo;
        if (gate && !gate_d) grise_c <= cyc;
        if (gate_d && !gate) fall_c <= cyc;
        if (uvlo && !uvlo_d) rise_c <= cyc;
    end

    task automatic end_of_test();
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_case(input row_s r);
        int t0, w, lim;
        logic fault;
        logic [2:0] st;
        fault = r.bopen || r.prog != 4'h0;
        st = (r.stat == 6'h00) ? RN : UV;
        lim = (r.sel || r.dem) ? LONG : SHORT;
        apb(1'b1, `PFP_A_IRQ_CLEAR, 32'h3F);
        sel <= r.sel;
        dem <= r.dem;
        peak <= r.peak;
        csm <= r.csm;
        ovm <= r.ovm;
        bopen <= r.bopen;
        prog <= r.prog;
        supply_on <= 1'b1;
        t0 = cyc;
        repeat (10) @(posedge pclk);
        chk(pbias, 1'b1);
        repeat (390) @(posedge pclk);
        if (r.prog == 4'h0) chk(breg, 1'b1);
        if (!fault) begin
            for (w = 0; gate !== 1'b1 && w < 2000; w++) @(posedge pclk);
            for (w = 0; gate === 1'b1 && w < 500; w++) @(posedge pclk);
            if (r.peak == 8'h00) chk(w, lim);
        end
        while (cyc - t0 < 1500) @(posedge pclk);
        if (fault) chk(grise_c < t0, 1'b1);
        if (r.bopen)
            chk(rise_c - t0 - BIAS10 inside {[0:8]}, 1'b1);
        chk(uvlo, st == UV);
        apb(1'b0, `PFP_A_STATE, 32'h0);
        chk(rd, {29'h0, st});
        apb(1'b0, `PFP_A_IRQ_STATUS, 32'h0);
        chk(rd, {26'h0, r.stat});
        if (!fault && st == UV)
            chk(rise_c - fall_c >= RC, r.stat[1:0] != 2'h0);
        supply_on <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, `PFP_A_STATE, 32'h0);
        chk(rd, 32'h0);
        chk(uvlo, 1'b0);
    endtask

    initial begin
        #2000000;
        failures++;
        end_of_test();
    end

    initial begin
        rows = '{
            '{1'b1, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 4'h0, 6'h01},
            '{1'b0, 1'b1, 8'h00, 8'h00, 8'h00, 1'b0, 4'h0, 6'h01},
            '{1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 4'h0, 6'h01},
            '{1'b0, 1'b0, 8'h0A, 8'h00, 8'h00, 1'b0, 4'h1, 6'h10},
            '{1'b0, 1'b0, 8'h0A, 8'h00, 8'h00, 1'b0, 4'h2, 6'h20},
            '{1'b0, 1'b0, 8'h0A, 8'h00, 8'h00, 1'b0, 4'h4, 6'h10},
            '{1'b0, 1'b0, 8'h0A, 8'h00, 8'h00, 1'b0, 4'h8, 6'h20},
            '{1'b0, 1'b0, 8'h0A, 8'hDB, 8'h00, 1'b0, 4'h0, 6'h00},
            '{1'b0, 1'b0, 8'h0A, 8'h0E, 8'h00, 1'b0, 4'h0, 6'h02},
            '{1'b0, 1'b0, 8'h0A, 8'h00, 8'h07, 1'b0, 4'h0, 6'h08},
            '{1'b0, 1'b0, 8'h0A, 8'h00, 8'hDB, 1'b0, 4'h0, 6'h00},
            '{1'b0, 1'b0, 8'h0A, 8'h00, 8'h00, 1'b1, 4'h0, 6'h04}};
        regs = '{{`PFP_A_CTRL, 31'h0, `PFP_CTRL_RST},
                 {`PFP_A_PERIOD, 16'h0000, `PFP_PERIOD_RST},
                 {`PFP_A_MAXON, 16'h0000, `PFP_MAXON_RST},
                 {`PFP_A_STATE, 32'h0}, {`PFP_A_IRQ_STATUS, 32'h0},
                 {`PFP_A_IRQ_ENABLE, 32'h0}, {`PFP_A_IRQ_CLEAR, 32'h0}};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) run_case(rows[i]);
        // Interrupt raised, masked, cleared
        chk(irq, 1'b0);
        apb(1'b1, `PFP_A_IRQ_ENABLE, 32'h04);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, `PFP_A_IRQ_ENABLE, 32'h3B);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, `PFP_A_IRQ_ENABLE, 32'h04);
        apb(1'b1, `PFP_A_IRQ_CLEAR, 32'h04);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, `PFP_A_MAXON, 32'h30);
        apb(1'b0, `PFP_A_MAXON, 32'h0);
        chk(rd, 32'h30);
        // Second reset, then reset values, read-only and unmapped places
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(uvlo, 1'b0);
        presetn <= 1'b1;
        foreach (regs[i]) begin
            apb(1'b0, regs[i][39:32], 32'h0);
            chk(rd, regs[i][31:0]);
            chk(err, 1'b0);
        end
        apb(1'b1, `PFP_A_STATE, 32'h7);
        apb(1'b0, `PFP_A_STATE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        end_of_test();
    end
endmodule // pin_fault_protection_tb
